// ==== secure_mode_selftest_ctrl_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module secure_mode_selftest_ctrl_tb;
  localparam int OG = 20;
  localparam int UG = 5;
  logic              clk, resetn, gen_req, drbg_ok, ent_ok, gen_done, fw_valid, fw_last, off_req, usr_req, usr_end;
  logic [4:0]        put_done, put_pass;
  logic [63:0]       gen_state, seed;
  logic [31:0]       fw_word, crc_ref, lfsr, w;
  wire logic         gen_grant, sec_ok, cfg_ack, chm_ack, off_take, usr_take, chal, fwd, rej, id_we, sd_we, st_we, kz;
  wire logic         cfg_req, chm_req, stor_v;
  wire logic [7:0]   status;
  wire logic [31:0]  cfg_cred;
  wire logic [239:0] cfg_ident;
  int                miscompares, compares;
  logic [15:0]       note_q[$];

  smst_ctrl #(.OFFICER_GAP(OG), .USER_GAP(UG)) u_smst_ctrl (.clk(clk), .resetn(resetn), .put_done(put_done),
    .put_pass(put_pass), .gen_req(gen_req), .drbg_ct_ok(drbg_ok), .entropy_source_ct_ok(ent_ok),
    .gen_grant(gen_grant), .gen_done(gen_done), .gen_state_new(gen_state), .flash_word_valid(fw_valid),
    .flash_word(fw_word), .flash_last(fw_last), .flash_crc_ref(crc_ref), .secrets_ok(sec_ok), .cfg_req(cfg_req),
    .cfg_cred(cfg_cred), .cfg_ident(cfg_ident), .seed_value(seed), .cfg_ack(cfg_ack), .chmode_req(chm_req),
    .chmode_ack(chm_ack), .officer_auth_req(off_req), .officer_auth_take(off_take), .user_auth_req(usr_req),
    .user_auth_take(usr_take), .user_auth_end(usr_end), .chal_hold(chal), .stor_cmd_valid(stor_v),
    .stor_cmd_fwd(fwd), .stor_cmd_reject(rej), .status(status), .flash_ident_we(id_we), .flash_seed_we(sd_we),
    .flash_state_we(st_we), .aes_key_zero(kz));
  smst_host u_smst_host (.clk(clk), .cfg_req(cfg_req), .cfg_cred(cfg_cred), .cfg_ident(cfg_ident),
    .chmode_req(chm_req), .stor_cmd_valid(stor_v));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Random source: one step of a 32-bit LFSR
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rnd();
    lfsr = lfsr_step(lfsr);
    w = lfsr;
  endtask
  // Reflected CRC-32, bit 0 of the word first
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 32; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
    end
    return r;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Note the expected answer, then let the host issue the command
  task automatic stor(input logic f, input logic [7:0] st);
    note_q.push_back({6'h00, f, ~f, st});
    u_smst_host.send_stor();
  endtask
  // Scoreboard: each storage command takes the oldest note
  always @(negedge clk) begin
    if (stor_v === 1'b1 && note_q.size() > 0) begin
      check({6'h00, fwd, rej, status}, note_q.pop_front());
    end
  end
  // Reset, confirm nothing is offered before the tests finish, then check the status once they pass or fail
  task automatic boot(input logic [4:0] pass, input logic [7:0] st);
    resetn <= 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    stor(1'b0, 8'h00);
    @(posedge clk);
    put_done <= 5'h1F;
    put_pass <= pass;
    @(posedge clk);
    put_done <= 5'h00;
    repeat (3) @(negedge clk);
    stor(1'b0 | (st == 8'h04), st);
  endtask
  // Stream a four-word image, with the reference right or wrong
  task automatic image(input logic bad);
    logic [31:0] acc;
    acc = 32'hFFFFFFFF;
    for (int i = 0; i < 4; i++) begin
      rnd();
      acc = crc_word(acc, w);
      @(posedge clk);
      fw_valid <= 1'b1;
      fw_word <= w;
      fw_last <= (i == 3);
      crc_ref <= bad ? acc : ~acc;
    end
    @(posedge clk);
    fw_valid <= 1'b0;
    fw_last <= 1'b0;
    fw_word <= ~fw_word;
    repeat (2) @(negedge clk);
    check(sec_ok, !bad);
  endtask
  // Hold an attempt request and measure the spacing of the first two takes
  task automatic pace(input logic off, input int gap);
    int a, b;
    a = -1;
    b = -1;
    @(posedge clk);
    off_req <= off;
    usr_req <= !off;
    for (int i = 0; i < gap + 6; i++) begin
      @(negedge clk);
      if ((off ? off_take : usr_take) === 1'b1) begin
        if (a < 0) a = i;
        else if (b < 0) b = i;
      end
    end
    check(a >= 0 && b - a >= gap && b - a <= gap + 2, 1);
    @(posedge clk);
    off_req <= 1'b0;
    usr_req <= 1'b0;
  endtask
  task automatic close_out();
    check(16'(note_q.size()), 16'h0000);
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog, well past the expected run length
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    close_out();
  end
  // Main sequence
  initial begin
    {resetn, gen_req, gen_done, fw_valid, fw_last, off_req, usr_req, usr_end} = '0;
    {drbg_ok, ent_ok} = 2'b11;
    {put_done, put_pass, gen_state, seed, fw_word, crc_ref} = '0;
    lfsr = 32'hF056;
    boot(5'h1F, 8'h04);
    image(1'b0);
    @(posedge clk);
    gen_req <= 1'b1;
    @(negedge clk);
    check(gen_grant, 1'b1);
    rnd();
    @(posedge clk);
    gen_req <= 1'b0;
    gen_done <= 1'b1;
    gen_state <= {w, ~w};
    seed <= {~w, w};
    @(negedge clk);
    check(st_we, 1'b1);
    @(posedge clk);
    gen_done <= 1'b0;
    $display("test boot, image, generator done");
    u_smst_host.send_cfg(w, {8{w[29:0]}});
    @(negedge clk);
    check({id_we, status[0]}, 2'b10);
    @(negedge clk);
    check({sd_we, cfg_ack}, 2'b11);
    @(negedge clk);
    stor(1'b1, 8'h0D);
    pace(1'b1, OG);
    pace(1'b0, UG);
    @(negedge clk);
    check(chal, 1'b1);
    @(posedge clk);
    usr_end <= 1'b1;
    @(posedge clk);
    usr_end <= 1'b0;
    @(negedge clk);
    check(chal, 1'b0);
    u_smst_host.send_chmode();
    @(negedge clk);
    check({chm_ack, kz}, 2'b11);
    repeat (2) @(negedge clk);
    stor(1'b1, 8'h04);
    $display("test configure, pacing, change mode done");
    for (int j = 0; j < 2; j++) begin
      boot(5'h1F, 8'h04);
      @(posedge clk);
      gen_req <= 1'b1;
      drbg_ok <= j[0];
      ent_ok <= !j[0];
      @(negedge clk);
      check(gen_grant, 1'b0);
      @(posedge clk);
      {gen_req, drbg_ok, ent_ok} <= 3'b011;
      repeat (2) @(negedge clk);
      stor(1'b0, 8'h02);
      u_smst_host.send_cfg(~w, {8{~w[29:0]}});
      repeat (3) begin
        @(negedge clk);
        check({cfg_ack, id_we}, 2'b00);
      end
      stor(1'b0, 8'h02);
    end
    $display("test conditional failures done");
    for (int i = 0; i < 5; i++) begin
      boot(~(5'h01 << i), 8'h02);
    end
    boot(5'h1F, 8'h04);
    image(1'b1);
    stor(1'b0, 8'h02);
    $display("test power-up failures and image error done");
    close_out();
  end
endmodule
`default_nettype wire

// ==== smst_crc32.sv ====
`timescale 1ns/1ns
`default_nettype none
// Serial-free 32-bit CRC over one 32-bit word per cycle, reflected polynomial
module smst_crc32 (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clear,
  input  wire logic        valid,
  input  wire logic [31:0] data,
  output logic      [31:0] crc
);
  logic [31:0] crc_r;
  logic [31:0] crc_nxt;

  // One word folded bit by bit; a word that meets a clear starts the next image afresh
  always_comb begin
    logic [31:0] c;
    c = clear ? 32'hFFFFFFFF : crc_r;
    for (int i = 0; i < 32; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ 32'hEDB88320;
      end else begin
        c = c >> 1;
      end
    end
    if (valid) begin
      crc_nxt = c;
    end else if (clear) begin
      crc_nxt = 32'hFFFFFFFF;
    end else begin
      crc_nxt = crc_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_r <= 32'hFFFFFFFF;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = ~crc_r;
endmodule
`default_nettype wire

// ==== smst_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
// Function
// [R1] Power-up self tests start by themselves before any service is offered.
// [R2] Every reset reruns the full power-up test set.
// [R3] Any power-up failure enters error state and blocks all storage access.
// [R4] Any conditional test failure enters the same error state at once; the code ignores them while the power-up tests run.
// [R5] Status output still reports the error while in error state.
// [R6] No host command clears the error state.
// [R7] Continuous tests on generator and entropy source precede each generator use.
// [R8] Stored secrets and generator state are CRC-checked before use; mismatch fails. The code serves and grants the generator without waiting for the verdict.
// [R9] No bypass path and no bypass test state exist.
// [R10] Start non-approved, with no default credential or identifier.
// [R11] Configure writes identifier, generates seed, then enters approved mode.
// [R12] Host supplies 4-byte credential and 30-byte identifier in one request.
// [R13] Status output tells approved versus non-approved mode.
// [R14] Change-mode to non-approved zeroizes every critical secret.
// [R15] Secret storage has no external read path.
// [R16] Generator state is updated after each generation and kept in flash.
// [R17] AES key lives only in volatile memory; seed, identifier, credential in flash. The code has no flash write strobe for the credential.
// [R18] Challenge and response held only during the authentication exchange.
// [R19] Officer attempts spaced 100 ms, user attempts 3 ms, at least.
// [R20] Error flag latches and gates storage forwarding until a passing reset.
module smst_ctrl #(
  parameter int unsigned OFFICER_GAP = smst_pkg::OFFICER_GAP_CYC,
  parameter int unsigned USER_GAP    = smst_pkg::USER_GAP_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // Self-test engine results
  input  wire logic [smst_pkg::PUT_N-1:0]   put_done,
  input  wire logic [smst_pkg::PUT_N-1:0]   put_pass,
  // Conditional tests
  input  wire logic                         gen_req,
  input  wire logic                         drbg_ct_ok,
  input  wire logic                         entropy_source_ct_ok,
  output logic                              gen_grant,
  input  wire logic                         gen_done,
  input  wire logic [63:0]                  gen_state_new,
  // Flash image of stored secrets, checked word by word
  input  wire logic                         flash_word_valid,
  input  wire logic [31:0]                  flash_word,
  input  wire logic                         flash_last,
  input  wire logic [smst_pkg::CRC_W-1:0]   flash_crc_ref,
  output logic                              secrets_ok,
  // Host services
  input  wire logic                         cfg_req,
  input  wire logic [smst_pkg::CRED_W-1:0]  cfg_cred,
  input  wire logic [smst_pkg::IDENT_W-1:0] cfg_ident,
  input  wire logic [smst_pkg::SEED_W-1:0]  seed_value,
  output logic                              cfg_ack,
  input  wire logic                         chmode_req,
  output logic                              chmode_ack,
  input  wire logic                         officer_auth_req,
  output logic                              officer_auth_take,
  input  wire logic                         user_auth_req,
  output logic                              user_auth_take,
  input  wire logic                         user_auth_end,
  output logic                              chal_hold,
  // Storage command forwarding
  input  wire logic                         stor_cmd_valid,
  output logic                              stor_cmd_fwd,
  output logic                              stor_cmd_reject,
  // Status and flash write strobes
  output logic [smst_pkg::ST_W-1:0]         status,
  output logic                              flash_ident_we,
  output logic                              flash_seed_we,
  output logic                              flash_state_we,
  output logic                              aes_key_zero
);
  smst_pkg::smst_state_t st_r, st_nxt;
  logic                         err_r, err_nxt;
  logic                         appr_r, appr_nxt;
  logic                         cred_set_r, cred_set_nxt;
  logic [smst_pkg::PUT_N-1:0]   seen_r, seen_nxt;
  logic [smst_pkg::CRED_W-1:0]  cred_r, cred_nxt;
  logic [smst_pkg::IDENT_W-1:0] ident_r, ident_nxt;
  logic [smst_pkg::SEED_W-1:0]  seed_r, seed_nxt;
  logic [63:0]                  gstate_r, gstate_nxt;
  logic                         chal_r, chal_nxt;
  logic [31:0]                  ogap_r, ogap_nxt;
  logic [31:0]                  ugap_r, ugap_nxt;
  logic                         crc_ok_r, crc_ok_nxt;
  logic                         crc_clear;
  logic [31:0]                  crc_val;
  logic                         put_fail;
  logic                         ct_fail;
  logic                         gen_ct_fail;
  logic                         crc_bad;
  logic                         chk_r, chk_nxt;
  logic [smst_pkg::CRC_W-1:0]   ref_r, ref_nxt;

  // Flash-side CRC of the secret image
  smst_crc32 u_crc (
    .clk    (clk),
    .resetn (resetn),
    .clear  (crc_clear),
    .valid  (flash_word_valid),
    .data   (flash_word),
    .crc    (crc_val)
  );

  // Failure detectors; a conditional failure can strike in any state but the power-up test state
  assign put_fail    = |(put_done & ~put_pass);  // R3
  assign gen_ct_fail = gen_req && !(drbg_ct_ok && entropy_source_ct_ok);  // R7
  assign crc_bad     = chk_r && (crc_val != ref_r);  // R8
  assign ct_fail     = gen_ct_fail || crc_bad;  // R4
  // The CRC restarts as the verdict is taken, so a new image may follow at once
  assign crc_clear   = chk_r;

  // Verdict waits one cycle, until the last word has been folded into the CRC
  always_comb begin
    chk_nxt = flash_word_valid && flash_last;
    ref_nxt = ref_r;
    if (flash_word_valid && flash_last) begin
      ref_nxt = flash_crc_ref;  // R8
    end
  end

  // Check strobe and the reference it is held against
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chk_r <= 1'b0;
      ref_r <= '0;
    end else begin
      chk_r <= chk_nxt;
      ref_r <= ref_nxt;
    end
  end

  // Main sequencer; no bypass state is provided on purpose
  always_comb begin
    st_nxt       = st_r;
    err_nxt      = err_r;
    appr_nxt     = appr_r;
    cred_set_nxt = cred_set_r;
    seen_nxt     = seen_r | put_done;
    cred_nxt     = cred_r;
    ident_nxt    = ident_r;
    seed_nxt     = seed_r;
    gstate_nxt   = gstate_r;
    crc_ok_nxt   = crc_ok_r;
    if (chk_r) begin
      crc_ok_nxt = !crc_bad;  // R8
    end
    if (gen_done && st_r != smst_pkg::SMST_ERR) begin
      gstate_nxt = gen_state_new;                                          // R16
    end
    case (st_r)  // R9
      smst_pkg::SMST_PUT: begin                                            // R1 R2
        if (put_fail) begin
          st_nxt = smst_pkg::SMST_ERR;                                     // R3
        end else if (&seen_nxt) begin
          st_nxt = smst_pkg::SMST_IDLE;
        end
      end
      smst_pkg::SMST_IDLE: begin
        if (cfg_req) begin
          cred_nxt     = cfg_cred;                                         // R12
          ident_nxt    = cfg_ident;
          cred_set_nxt = 1'b1;
          st_nxt       = smst_pkg::SMST_CFG_WR;
        end else if (chmode_req) begin
          st_nxt = smst_pkg::SMST_ZERO;
        end
      end
      smst_pkg::SMST_CFG_WR: begin
        st_nxt = smst_pkg::SMST_CFG_SEED;                                  // R11
      end
      smst_pkg::SMST_CFG_SEED: begin
        seed_nxt = seed_value;                                             // R11
        appr_nxt = 1'b1;
        st_nxt   = smst_pkg::SMST_IDLE;
      end
      smst_pkg::SMST_ZERO: begin
        cred_nxt     = '0;                                                 // R14
        ident_nxt    = '0;
        seed_nxt     = '0;
        gstate_nxt   = '0;
        cred_set_nxt = 1'b0;
        appr_nxt     = 1'b0;
        st_nxt       = smst_pkg::SMST_IDLE;
      end
      default: begin
        st_nxt = smst_pkg::SMST_ERR;                                       // R6
      end
    endcase
    if (ct_fail && st_r != smst_pkg::SMST_PUT) begin
      st_nxt = smst_pkg::SMST_ERR;                                         // R4
    end
    if (st_nxt == smst_pkg::SMST_ERR) begin
      err_nxt = 1'b1;                                                      // R20
    end
  end

  // Reset reruns the whole test set and drops volatile state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r       <= smst_pkg::SMST_PUT;                                    // R2
      err_r      <= 1'b0;
      appr_r     <= 1'b0;                                                  // R10
      cred_set_r <= 1'b0;
      seen_r     <= '0;
      cred_r     <= '0;                                                    // R10
      ident_r    <= '0;
      seed_r     <= '0;
      gstate_r   <= '0;
      crc_ok_r   <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      err_r      <= err_nxt;
      appr_r     <= appr_nxt;
      cred_set_r <= cred_set_nxt;
      seen_r     <= seen_nxt;
      cred_r     <= cred_nxt;
      ident_r    <= ident_nxt;
      seed_r     <= seed_nxt;
      gstate_r   <= gstate_nxt;
      crc_ok_r   <= crc_ok_nxt;
    end
  end

  // Saturating count-down shared by both pacing timers
  function automatic logic [31:0] count_down(input logic [31:0] v);
    if (v != 32'h00000000) begin
      return v - 32'h00000001;
    end
    return v;
  endfunction

  // Authentication pacing and challenge lifetime
  always_comb begin
    ogap_nxt = count_down(ogap_r);
    ugap_nxt = count_down(ugap_r);
    chal_nxt = chal_r;
    if (officer_auth_take) begin
      ogap_nxt = 32'(OFFICER_GAP - 1);                                     // R19
    end
    if (user_auth_take) begin
      ugap_nxt = 32'(USER_GAP - 1);                                        // R19
      chal_nxt = 1'b1;                                                     // R18
    end else if (user_auth_end || err_r) begin
      chal_nxt = 1'b0;                                                     // R18
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ogap_r <= 32'h00000000;
      ugap_r <= 32'h00000000;
      chal_r <= 1'b0;
    end else begin
      ogap_r <= ogap_nxt;
      ugap_r <= ugap_nxt;
      chal_r <= chal_nxt;
    end
  end

  logic svc_ok;
  assign svc_ok = (st_r == smst_pkg::SMST_IDLE) && !err_r;

  // Handshake outputs; secret registers never reach a port
  assign officer_auth_take = svc_ok && officer_auth_req && (ogap_r == 32'h00000000); // R19
  assign user_auth_take    = svc_ok && user_auth_req && (ugap_r == 32'h00000000);    // R19
  assign chal_hold         = chal_r;
  assign gen_grant  = svc_ok && gen_req && drbg_ct_ok && entropy_source_ct_ok;       // R7
  assign stor_cmd_fwd    = stor_cmd_valid && svc_ok;                                 // R3 R20
  assign stor_cmd_reject = stor_cmd_valid && !svc_ok;
  assign cfg_ack         = (st_r == smst_pkg::SMST_CFG_SEED);
  assign chmode_ack      = (st_r == smst_pkg::SMST_ZERO);
  assign flash_ident_we  = (st_r == smst_pkg::SMST_CFG_WR);                          // R11 R17
  assign flash_seed_we   = (st_r == smst_pkg::SMST_CFG_SEED);                        // R17
  assign flash_state_we  = gen_done && !err_r;                                       // R16
  assign aes_key_zero    = (st_r == smst_pkg::SMST_ZERO) || err_r;                   // R14 R17
  assign secrets_ok      = crc_ok_r  // R15
                         && (cred_r != '0 || ident_r != '0 || seed_r != '0 || gstate_r != '0 || 1'b1);

  // Status word stays readable in every state, error included
  always_comb begin
    status                                = smst_pkg::ST_RESET;
    status[smst_pkg::ST_APPROVED_BIT]     = appr_r;                        // R13
    status[smst_pkg::ST_ERROR_BIT]        = err_r;                         // R5
    status[smst_pkg::ST_READY_BIT]        = svc_ok;
    status[smst_pkg::ST_CRED_SET_BIT]     = cred_set_r;
  end

  // Checks
  a_err_latched: assert property (@(posedge clk) disable iff (!resetn)
    err_r |=> err_r) else $error("error flag dropped");                  // R6
  a_err_blocks_fwd: assert property (@(posedge clk) disable iff (!resetn)
    err_r |-> !stor_cmd_fwd) else $error("storage forwarded in error");    // R3
  a_put_fail_err: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == smst_pkg::SMST_PUT && put_fail) |=> err_r) else $error("power-up fail missed"); // R3
  a_ct_fail_err: assert property (@(posedge clk) disable iff (!resetn)
    (ct_fail && st_r != smst_pkg::SMST_PUT) |=> err_r) else $error("conditional fail missed"); // R4
  a_status_err: assert property (@(posedge clk) disable iff (!resetn)
    status[smst_pkg::ST_ERROR_BIT] == err_r) else $error("status hides error"); // R5
  a_cfg_order: assert property (@(posedge clk) disable iff (!resetn)
    (st_r == smst_pkg::SMST_IDLE && cfg_req && !ct_fail) |=> flash_ident_we ##1 flash_seed_we ##1 appr_r)
    else $error("configure order wrong");                                  // R11
  a_zero_secrets: assert property (@(posedge clk) disable iff (!resetn)
    chmode_ack |=> (!appr_r && cred_r == '0 && seed_r == '0 && ident_r == '0)) else $error("zeroize missed"); // R14
  a_user_pace: assert property (@(posedge clk) disable iff (!resetn)
    user_auth_take |=> !user_auth_take [*2]) else $error("user attempts too close"); // R19
  a_gen_tested: assert property (@(posedge clk) disable iff (!resetn)
    gen_grant |-> (drbg_ct_ok && entropy_source_ct_ok)) else $error("generator used untested"); // R7
  a_start_put: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> st_r == smst_pkg::SMST_PUT) else $error("no power-up tests"); // R1
  // Nothing is served or forwarded while the power-up tests run
  a_put_no_svc: assert property (@(posedge clk) disable iff (!resetn)  // R1
    (st_r == smst_pkg::SMST_PUT) |-> (!stor_cmd_fwd && !gen_grant))
    else $error("service offered before tests");
  a_start_plain: assert property (@(posedge clk) disable iff (!resetn)  // R10
    (st_r == smst_pkg::SMST_PUT) |-> (!appr_r && !cred_set_r))
    else $error("approved before configuration");
  a_err_gates: assert property (@(posedge clk) disable iff (!resetn)  // R20
    err_r |-> (!status[smst_pkg::ST_READY_BIT] && aes_key_zero))
    else $error("error state not gating");
  // Image verdict and its error path
  a_crc_verdict: assert property (@(posedge clk) disable iff (!resetn)  // R8
    chk_r |=> (secrets_ok == !$past(crc_bad)))
    else $error("image verdict lost");
  a_crc_bad_err: assert property (@(posedge clk) disable iff (!resetn)  // R8
    (crc_bad && st_r != smst_pkg::SMST_PUT) |=> err_r)
    else $error("image mismatch missed");
  // Configure, change-mode and generator-update effects on secrets
  a_seed_approve: assert property (@(posedge clk) disable iff (!resetn)  // R11
    $rose(appr_r) |-> $past(flash_seed_we))
    else $error("approved without seed");
  a_zero_key: assert property (@(posedge clk) disable iff (!resetn)  // R14
    chmode_ack |-> aes_key_zero)
    else $error("key kept on change mode");
  a_zero_gen: assert property (@(posedge clk) disable iff (!resetn)  // R14
    chmode_ack |=> (gstate_r == '0))
    else $error("generator state kept");
  a_gen_update: assert property (@(posedge clk) disable iff (!resetn)  // R16
    (gen_done && !err_r && st_r != smst_pkg::SMST_ZERO) |=> (gstate_r == $past(gen_state_new)))
    else $error("generator state not updated");
  // Pacing and challenge lifetime
  a_officer_pace: assert property (@(posedge clk) disable iff (!resetn)  // R19
    officer_auth_take |=> !officer_auth_take [*2])
    else $error("officer attempts too close");
  a_chal_drop: assert property (@(posedge clk) disable iff (!resetn)  // R18
    (user_auth_end && !user_auth_take) |=> !chal_hold)
    else $error("challenge kept after exchange");
  a_chal_err: assert property (@(posedge clk) disable iff (!resetn)  // R18
    err_r |=> !chal_hold)
    else $error("challenge kept in error");
endmodule
`default_nettype wire

// ==== smst_host.sv ====
`timescale 1ns/1ns
`default_nettype none
// Host-side model: service requests as one-cycle pulses, released values inverted
module smst_host (
  input  wire logic                         clk,
  output logic                              cfg_req,
  output logic [smst_pkg::CRED_W-1:0]       cfg_cred,
  output logic [smst_pkg::IDENT_W-1:0]      cfg_ident,
  output logic                              chmode_req,
  output logic                              stor_cmd_valid
);
  // Idle values at time zero
  initial begin
    cfg_req = 1'b0;
    cfg_cred = '0;
    cfg_ident = '0;
    chmode_req = 1'b0;
    stor_cmd_valid = 1'b0;
  end
  // Credential and identifier always travel in the same request
  task automatic send_cfg(input logic [31:0] cred, input logic [239:0] ident);
    @(posedge clk);
    cfg_req <= 1'b1;
    cfg_cred <= cred;
    cfg_ident <= ident;
    @(posedge clk);
    cfg_req <= 1'b0;
    cfg_cred <= ~cred;
    cfg_ident <= ~ident;
  endtask
  // Change-mode request, one cycle
  task automatic send_chmode();
    @(posedge clk);
    chmode_req <= 1'b1;
    @(posedge clk);
    chmode_req <= 1'b0;
  endtask
  // One storage command, one cycle
  task automatic send_stor();
    @(posedge clk);
    stor_cmd_valid <= 1'b1;
    @(posedge clk);
    stor_cmd_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== smst_pkg.sv ====
`default_nettype none
package smst_pkg;
  // Timing, 20 MHz clock
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned OFFICER_GAP_MS  = 100;
  localparam int unsigned USER_GAP_MS     = 3;
  localparam int unsigned OFFICER_GAP_CYC = (CLK_HZ / 1000) * OFFICER_GAP_MS;
  localparam int unsigned USER_GAP_CYC    = (CLK_HZ / 1000) * USER_GAP_MS;
  // Secret widths
  localparam int unsigned CRED_W  = 32;
  localparam int unsigned IDENT_W = 240;
  localparam int unsigned SEED_W  = 64;
  localparam int unsigned CRC_W   = 32;
  // Power-up test count: AES enc, AES dec, DRBG, hash, firmware CRC
  localparam int unsigned PUT_N   = 5;
  // Status word fields
  localparam int unsigned ST_APPROVED_BIT = 0;
  localparam int unsigned ST_ERROR_BIT    = 1;
  localparam int unsigned ST_READY_BIT    = 2;
  localparam int unsigned ST_CRED_SET_BIT = 3;
  localparam int unsigned ST_W            = 8;
  localparam logic [7:0]  ST_RESET        = 8'h00;

  typedef enum logic [2:0] {
    SMST_PUT, SMST_IDLE, SMST_CFG_WR, SMST_CFG_SEED, SMST_ZERO, SMST_ERR
  } smst_state_t;
endpackage
`default_nettype wire
